// ---- core/oprp_consts.svh ----
`ifndef OPRP_CONSTS_SVH
`define OPRP_CONSTS_SVH

// ***********************************************
// register map, byte addresses on the apb side
// ***********************************************
`define OPRP_REG_CTRL      12'h000
`define OPRP_REG_ADDR      12'h004
`define OPRP_REG_WDATA     12'h008
`define OPRP_REG_STATUS    12'h00c
`define OPRP_REG_RDATA     12'h010

// ***********************************************
// field positions and encodings
// ***********************************************
`define OPRP_CMD_LSB       0
`define OPRP_CMD_MSB       2
`define OPRP_CTRL_HIBYTE   8
`define OPRP_CMD_NONE      3'h0
`define OPRP_CMD_RD_WORD   3'h1
`define OPRP_CMD_RD_BYTE   3'h2
`define OPRP_CMD_RD_ID     3'h3
`define OPRP_CMD_PROGRAM   3'h4
`define OPRP_CMD_VERIFY    3'h5
`define OPRP_ST_BUSY       0
`define OPRP_ST_DONE       1
`define OPRP_ST_FAIL       2
`define OPRP_ST_PARITY_OK  3
`define OPRP_ST_CNT_LSB    8
`define OPRP_ERASED_WORD   16'hffff

// ***********************************************
// timing
// ***********************************************
`define OPRP_CLK_NS        10
`define OPRP_PULSE_US      100
`define OPRP_PULSE_CYC     ((`OPRP_PULSE_US * 1000) / `OPRP_CLK_NS)
`define OPRP_ACCESS_NS     150
`define OPRP_ACCESS_CYC    ((`OPRP_ACCESS_NS + `OPRP_CLK_NS - 1) / `OPRP_CLK_NS)
`define OPRP_SETTLE_NS     100
`define OPRP_SETTLE_CYC    ((`OPRP_SETTLE_NS + `OPRP_CLK_NS - 1) / `OPRP_CLK_NS)
`define OPRP_SUPPLY_US     1
`define OPRP_SUPPLY_CYC    ((`OPRP_SUPPLY_US * 1000) / `OPRP_CLK_NS)
`define OPRP_SYNC_STAGES   2
`define OPRP_MAX_PULSES    25

`endif

// ---- core/oprp_pkg.sv ----
package oprp_pkg;

   typedef enum logic [6:0] {
      OPRP_IDLE   = 7'b0000001,
      OPRP_RAISE  = 7'b0000010,
      OPRP_SETUP  = 7'b0000100,
      OPRP_PULSE  = 7'b0001000,
      OPRP_SAMPLE = 7'b0010000,
      OPRP_CHECK  = 7'b0100000,
      OPRP_LOWER  = 7'b1000000
   } oprp_state_e;

   // levels driven toward the memory pins
   typedef struct packed {
      logic [17:0] addr;
      logic [15:0] dout;
      logic [15:0] doe;
      logic        cs_n;
      logic        og_n;
      logic        word_mode;
      logic        prog_raise;
      logic        core_raise;
      logic        id_hv;
   } oprp_pins_s;

endpackage

// ---- core/oprp_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

// ***********************************************
// two-flop synchroniser, one chain per bit
// ***********************************************
module oprp_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_q;
         logic stable_q;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q   <= 1'b0;
               stable_q <= 1'b0;
            end else begin
               meta_q   <= async_in[i];
               stable_q <= meta_q;
            end
         end
         assign sync_out[i] = stable_q;
      end
   endgenerate

endmodule

`default_nettype wire

// ---- core/oprp_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "oprp_consts.svh"

module oprp_ctrl
   import oprp_pkg::*;
#(
   parameter int PULSE_CYC  = `OPRP_PULSE_CYC,
   parameter int SUPPLY_CYC = `OPRP_SUPPLY_CYC,
   parameter int MAX_PULSES = `OPRP_MAX_PULSES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [17:0] address_lines,
   input  wire logic [15:0] data_lines_i,
   output logic      [15:0] data_lines_o,
   output logic      [15:0] data_lines_oe,
   output logic             chip_select_n,
   output logic             output_gate_n,
   output logic             width_sel_word,
   output logic             prog_supply_raise,
   output logic             core_supply_raise,
   output logic             id_mode_hv_line
);

   // ***********************************************
   // apb slave
   // ***********************************************
   logic        acc;
   logic        sel_ctrl;
   logic        sel_addr;
   logic        sel_wdata;
   logic        sel_status;
   logic        sel_rdata;
   logic        mapped;
   logic        cmd_wr;
   logic [2:0]  wr_cmd;

   assign acc        = psel & penable;
   assign sel_ctrl   = (paddr == `OPRP_REG_CTRL);
   assign sel_addr   = (paddr == `OPRP_REG_ADDR);
   assign sel_wdata  = (paddr == `OPRP_REG_WDATA);
   assign sel_status = (paddr == `OPRP_REG_STATUS);
   assign sel_rdata  = (paddr == `OPRP_REG_RDATA);
   assign mapped     = sel_ctrl | sel_addr | sel_wdata | sel_status | sel_rdata;
   assign pready     = 1'b1;
   assign pslverr    = acc & ~mapped;
   assign wr_cmd     = pwdata[`OPRP_CMD_MSB:`OPRP_CMD_LSB];

   oprp_state_e state_q;
   oprp_state_e state_d;
   oprp_pins_s  pins_q;
   oprp_pins_s  pins_d;
   logic [17:0] addr_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic [2:0]  cmd_q;
   logic [2:0]  cmd_d;
   logic        hibyte_q;
   logic        done_q;
   logic        done_d;
   logic        fail_q;
   logic        fail_d;
   logic        par_ok_q;
   logic        par_ok_d;
   logic [4:0]  pulses_q;
   logic [4:0]  pulses_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic        busy;

   assign busy   = (state_q != OPRP_IDLE);
   // commands written while busy are dropped; software polls busy first
   assign cmd_wr = acc & pwrite & sel_ctrl & ~busy & (wr_cmd != `OPRP_CMD_NONE);

   logic [31:0] rd_word;
   assign rd_word = sel_ctrl   ? {23'h0, hibyte_q, 5'h0, cmd_q} :
                    sel_addr   ? {14'h0, addr_q} :
                    sel_wdata  ? {16'h0, wdata_q} :
                    sel_status ? {19'h0, pulses_q, 4'h0, par_ok_q, fail_q, done_q, busy} :
                    sel_rdata  ? {16'h0, rdata_q} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q   <= 18'h0;
         wdata_q  <= `OPRP_ERASED_WORD;
         hibyte_q <= 1'b0;
         prdata   <= 32'h0;
      end else begin
         prdata   <= (psel & ~penable & ~pwrite) ? rd_word : 32'h0;
         if (acc & pwrite & sel_addr & ~busy) begin
            addr_q <= pwdata[17:0];
         end
         if (acc & pwrite & sel_wdata & ~busy) begin
            wdata_q <= pwdata[15:0];
         end
         if (cmd_wr) begin
            hibyte_q <= pwdata[`OPRP_CTRL_HIBYTE];
         end
      end
   end

   // ***********************************************
   // pin input capture
   // ***********************************************
   logic [15:0] din;

   oprp_sync #(
      .WIDTH (16)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (data_lines_i),
      .sync_out (din)
   );

   // ***********************************************
   // sequencing
   // ***********************************************
   logic        is_prog;
   logic        is_ver;
   logic        is_id;
   logic        is_byte;
   logic [17:0] pin_addr;
   logic [15:0] byte_sel;
   logic        id_parity;
   logic        match;
   logic [15:0] sample_cyc;
   logic [15:0] settle_cyc;
   logic [15:0] pulse_cyc;
   logic [15:0] supply_cyc;

   assign is_prog    = (cmd_q == `OPRP_CMD_PROGRAM);
   assign is_ver     = (cmd_q == `OPRP_CMD_VERIFY);
   assign is_id      = (cmd_q == `OPRP_CMD_RD_ID);
   assign is_byte    = (cmd_q == `OPRP_CMD_RD_BYTE);
   assign sample_cyc = 16'(`OPRP_ACCESS_CYC + `OPRP_SYNC_STAGES);
   assign settle_cyc = 16'(`OPRP_SETTLE_CYC);
   assign pulse_cyc  = 16'(PULSE_CYC);
   assign supply_cyc = 16'(SUPPLY_CYC);
   // identify: upper address lines held low
   assign pin_addr   = is_id ? {17'h0, addr_q[0]} : addr_q;
   // byte mode returns the selected half on lines 0-7
   assign byte_sel   = {8'h00, din[7:0]};
   // odd parity check over the returned identify word
   assign id_parity  = ^din;
   // a word that asks to set a cleared cell can never match
   assign match      = (din == wdata_q);

   always_comb begin
      state_d  = state_q;
      pins_d   = pins_q;
      cnt_d    = (cnt_q != 16'h0) ? cnt_q - 16'h1 : 16'h0;
      cmd_d    = cmd_q;
      rdata_d  = rdata_q;
      done_d   = done_q;
      fail_d   = fail_q;
      par_ok_d = par_ok_q;
      pulses_d = pulses_q;
      case (state_q)
         OPRP_IDLE: begin
            if (cmd_wr) begin
               cmd_d       = wr_cmd;
               done_d      = 1'b0;
               fail_d      = 1'b0;
               pulses_d    = 5'h0;
               pins_d.addr = (wr_cmd == `OPRP_CMD_RD_ID) ? {17'h0, addr_q[0]} : addr_q;
               // byte mode: width select low, line 15 carries the half select
               if (wr_cmd == `OPRP_CMD_RD_BYTE) begin
                  pins_d.word_mode = 1'b0;
                  pins_d.dout      = {pwdata[`OPRP_CTRL_HIBYTE], 15'h0};
                  pins_d.doe       = 16'h8000;
               end
               // identify voltage raised before the read
               pins_d.id_hv = (wr_cmd == `OPRP_CMD_RD_ID);
               if ((wr_cmd == `OPRP_CMD_PROGRAM) || (wr_cmd == `OPRP_CMD_VERIFY)) begin
                  // gate held high as the supplies go up
                  pins_d.og_n       = 1'b1;
                  pins_d.prog_raise = 1'b1;
                  pins_d.core_raise = (wr_cmd == `OPRP_CMD_PROGRAM);
               end
               cnt_d   = supply_cyc;
               state_d = OPRP_RAISE;
            end
         end
         OPRP_RAISE: begin
            if (cnt_q == 16'h0) begin
               if (is_prog) begin
                  // full word on all sixteen lines at once
                  pins_d.dout = wdata_q;
                  pins_d.doe  = 16'hffff;
                  cnt_d       = settle_cyc;
                  state_d     = OPRP_SETUP;
               end else begin
                  // select and gate both low for a read
                  // verify keeps select high, gate low, supply raised
                  pins_d.cs_n = is_ver;
                  pins_d.og_n = 1'b0;
                  cnt_d       = sample_cyc;
                  state_d     = OPRP_SAMPLE;
               end
            end
         end
         OPRP_SETUP: begin
            // pulse only after address and data have settled
            if (cnt_q == 16'h0) begin
               pins_d.cs_n = 1'b0;
               pulses_d    = pulses_q + 5'h1;
               cnt_d       = pulse_cyc - 16'h1;
               state_d     = OPRP_PULSE;
            end
         end
         OPRP_PULSE: begin
            if (cnt_q == 16'h0) begin
               // select high again, then read back with the supply still up
               pins_d.cs_n = 1'b1;
               pins_d.doe  = 16'h0;
               pins_d.og_n = 1'b0;
               cnt_d       = sample_cyc;
               state_d     = OPRP_SAMPLE;
            end
         end
         OPRP_SAMPLE: begin
            if (cnt_q == 16'h0) begin
               rdata_d     = is_byte ? byte_sel : din;
               par_ok_d    = is_id ? id_parity : par_ok_q;
               // gate released first so the device floats before the next step
               pins_d.og_n = 1'b1;
               state_d     = OPRP_CHECK;
            end
         end
         OPRP_CHECK: begin
            // another pulse on mismatch, giving up after the limit
            if (is_prog && !match && (pulses_q < 5'(MAX_PULSES))) begin
               pins_d.dout = wdata_q;
               pins_d.doe  = 16'hffff;
               cnt_d       = settle_cyc;
               state_d     = OPRP_SETUP;
            end else begin
               fail_d = (is_prog | is_ver) & !match;
               pins_d.cs_n       = 1'b1;
               pins_d.doe        = 16'h0;
               pins_d.dout       = 16'h0;
               pins_d.prog_raise = 1'b0;
               pins_d.core_raise = 1'b0;
               pins_d.id_hv      = 1'b0;
               pins_d.word_mode  = 1'b1;
               cnt_d             = supply_cyc;
               state_d           = OPRP_LOWER;
            end
         end
         OPRP_LOWER: begin
            // supplies back at normal before any re-verify read
            if (cnt_q == 16'h0) begin
               done_d  = 1'b1;
               state_d = OPRP_IDLE;
            end
         end
         default: begin
            state_d = OPRP_IDLE;
         end
      endcase
      if (state_q != OPRP_IDLE) begin
         pins_d.addr = pin_addr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= OPRP_IDLE;
         pins_q   <= '{addr: 18'h0, dout: 16'h0, doe: 16'h0, cs_n: 1'b1, og_n: 1'b1,
                       word_mode: 1'b1, prog_raise: 1'b0, core_raise: 1'b0, id_hv: 1'b0};
         cnt_q    <= 16'h0;
         cmd_q    <= `OPRP_CMD_NONE;
         rdata_q  <= 16'h0;
         done_q   <= 1'b0;
         fail_q   <= 1'b0;
         par_ok_q <= 1'b0;
         pulses_q <= 5'h0;
      end else begin
         state_q  <= state_d;
         pins_q   <= pins_d;
         cnt_q    <= cnt_d;
         cmd_q    <= cmd_d;
         rdata_q  <= rdata_d;
         done_q   <= done_d;
         fail_q   <= fail_d;
         par_ok_q <= par_ok_d;
         pulses_q <= pulses_d;
      end
   end

   // ***********************************************
   // pin drive
   // ***********************************************
   // per-device select and gate; supplies as levels
   assign address_lines     = pins_q.addr;
   assign data_lines_o      = pins_q.dout;
   assign data_lines_oe     = pins_q.doe;
   assign chip_select_n     = pins_q.cs_n;
   assign output_gate_n     = pins_q.og_n;
   assign width_sel_word    = pins_q.word_mode;
   assign prog_supply_raise = pins_q.prog_raise;
   assign core_supply_raise = pins_q.core_raise;
   assign id_mode_hv_line   = pins_q.id_hv;

endmodule

`default_nettype wire

// ---- verif/oprp_ctrl_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "oprp_consts.svh"

// *****************************
// apb and pin-side rules of the controller
// *****************************
module oprp_ctrl_chk #(
   parameter int PULSE_CYC  = 10000,
   parameter int SUPPLY_CYC = 100,
   parameter int MAX_PULSES = 25
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic [11:0] paddr,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [17:0] address_lines,
   input  wire logic [15:0] data_lines_o,
   input  wire logic [15:0] data_lines_oe,
   input  wire logic        chip_select_n,
   input  wire logic        output_gate_n,
   input  wire logic        width_sel_word,
   input  wire logic        prog_supply_raise,
   input  wire logic        core_supply_raise,
   input  wire logic        id_mode_hv_line
);
   logic [15:0] low_q;
   logic [5:0]  np_q;
   logic        cs_q;
   wire         prog_low = !chip_select_n && prog_supply_raise;
   wire         mapped   = paddr inside {`OPRP_REG_CTRL, `OPRP_REG_ADDR, `OPRP_REG_WDATA,
                                         `OPRP_REG_STATUS, `OPRP_REG_RDATA};

   // pulse length and pulses per programming session
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_q <= '0;
         np_q  <= '0;
         cs_q  <= 1'b1;
      end else begin
         low_q <= prog_low ? low_q + 16'h1 : 16'h0;
         np_q  <= !prog_supply_raise ? 6'h0 : np_q + 6'(cs_q && !chip_select_n);
         cs_q  <= chip_select_n;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   apb_unmapped_a: assert property (psel && penable && !mapped |-> pslverr)
      else $error("unmapped access without error");
   pulse_drive_a: assert property (
      prog_low |-> output_gate_n && core_supply_raise && data_lines_oe == 16'hffff)
      else $error("pulse without full word or raised supplies");
   pulse_settle_a: assert property (
      $fell(chip_select_n) && prog_supply_raise |-> $stable(address_lines) && $stable(data_lines_o))
      else $error("pulse began before lines settled");
   pulse_hold_a: assert property (
      prog_low ##1 prog_low |-> $stable(address_lines) && $stable(data_lines_o))
      else $error("lines moved during pulse");
   pulse_len_a: assert property (
      $rose(chip_select_n) && prog_supply_raise |-> low_q == PULSE_CYC)
      else $error("pulse length wrong");
   pulse_cap_a: assert property (low_q <= PULSE_CYC)
      else $error("pulse too long");
   pulse_max_a: assert property (np_q <= MAX_PULSES)
      else $error("too many pulses");
   verify_sel_a: assert property (
      prog_supply_raise && !output_gate_n |-> chip_select_n && data_lines_oe == 16'h0)
      else $error("verify with select low or lines driven");
   id_addr_a: assert property (
      id_mode_hv_line |-> address_lines[17:1] == 17'h0 && width_sel_word && !prog_supply_raise)
      else $error("identify with wrong address or mode");
   bus_free_a: assert property (
      !output_gate_n |-> data_lines_oe[14:0] == 15'h0 && !(width_sel_word && data_lines_oe[15]))
      else $error("controller drives data while gate low");
endmodule

bind oprp_ctrl oprp_ctrl_chk #(.PULSE_CYC(PULSE_CYC), .SUPPLY_CYC(SUPPLY_CYC),
   .MAX_PULSES(MAX_PULSES)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .address_lines(address_lines), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
   .chip_select_n(chip_select_n), .output_gate_n(output_gate_n), .width_sel_word(width_sel_word),
   .prog_supply_raise(prog_supply_raise), .core_supply_raise(core_supply_raise),
   .id_mode_hv_line(id_mode_hv_line));
`default_nettype wire

// ---- verif/oprp_rom_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// *****************************
// behavioural memory device
// *****************************
module oprp_rom_model #(
   parameter logic [15:0] MAKER_WORD = 16'h0034, // arbitrary value, odd parity
   parameter logic [15:0] PART_WORD  = 16'h8003  // arbitrary value, odd parity
) (
   input  wire logic [17:0] address_lines,
   input  wire logic [15:0] data_lines,
   input  wire logic        chip_select_n,
   input  wire logic        output_gate_n,
   input  wire logic        width_sel_word,
   input  wire logic        prog_supply_raise,
   input  wire logic        core_supply_raise,
   input  wire logic        id_mode_hv_line,
   output logic      [15:0] q,
   output logic      [15:0] q_oe
);
   // only 16 words kept, upper address bits alias
   logic [15:0] mem [16];
   logic [15:0] word;
   wire  [3:0]  idx    = address_lines[3:0];
   wire         sel_rd = !chip_select_n && !output_gate_n;
   wire         sel_vf = chip_select_n && !output_gate_n && prog_supply_raise;

   initial foreach (mem[i]) mem[i] = 16'hffff;
   // pulse clears bits only, high select inhibits
   always @(negedge chip_select_n)
      if (prog_supply_raise && core_supply_raise && output_gate_n) mem[idx] = mem[idx] & data_lines;
   assign word = (id_mode_hv_line && !prog_supply_raise) ?
                 (address_lines[0] ? PART_WORD : MAKER_WORD) : mem[idx];
   // drive when selected and gated, or in verify
   assign q_oe = !(sel_rd || sel_vf) ? 16'h0 : width_sel_word ? 16'hffff : 16'h00ff;
   // byte mode: line 15 picks the half, upper lines float
   assign q    = width_sel_word ? word : {8'h00, data_lines[15] ? word[15:8] : word[7:0]};
endmodule
`default_nettype wire

// ---- verif/oprp_ctrl_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "oprp_consts.svh"

module oprp_ctrl_bench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rv, st;
   logic        pready, pslverr, cs_n, og_n, w_sel, pr, cr, idl;
   logic [17:0] a_l;
   logic [15:0] c_o, c_oe, m_q, m_oe, bus, flt = '0;
   int          bad_count = 0, checks = 0, cyc = 0;

   // released lines show the inverse of what they carried last
   assign bus = (c_oe & c_o) | (~c_oe & m_oe & m_q) | (~c_oe & ~m_oe & flt);
   always @(posedge pclk) flt <= ~bus;

   oprp_ctrl #(.PULSE_CYC(20), .SUPPLY_CYC(4), .MAX_PULSES(25)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .address_lines(a_l), .data_lines_i(bus), .data_lines_o(c_o), .data_lines_oe(c_oe),
      .chip_select_n(cs_n), .output_gate_n(og_n), .width_sel_word(w_sel),
      .prog_supply_raise(pr), .core_supply_raise(cr), .id_mode_hv_line(idl));
   oprp_rom_model rom (.address_lines(a_l), .data_lines(bus), .chip_select_n(cs_n),
      .output_gate_n(og_n), .width_sel_word(w_sel), .prog_supply_raise(pr),
      .core_supply_raise(cr), .id_mode_hv_line(idl), .q(m_q), .q_oe(m_oe));

   initial forever #5 pclk = ~pclk;

   // *****************************
   // apb access and checking
   // *****************************
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // one command, polled to completion; leaves status in st and read data in rv
   task automatic run(input logic [2:0] c, input logic [17:0] a, input logic [15:0] w,
                      input logic hi, input logic [31:0] mask, input logic [31:0] es);
      xfer(1'b1, `OPRP_REG_ADDR, {14'h0, a});
      xfer(1'b1, `OPRP_REG_WDATA, {16'h0, w});
      xfer(1'b1, `OPRP_REG_CTRL, {23'h0, hi, 5'h0, c});
      do xfer(1'b0, `OPRP_REG_STATUS, 32'h0); while (rv[0] !== 1'b0);
      st = rv;
      chk(st & mask, es, "status");
      xfer(1'b0, `OPRP_REG_RDATA, 32'h0);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // *****************************
   // scenarios
   // *****************************
   initial begin
      logic [17:0] adr [2];
      logic [15:0] val [2];
      adr = '{18'h3, 18'h5};
      val = '{16'h00a5, 16'hbeef};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, `OPRP_REG_STATUS, 32'h0);
      chk(rv, 32'h0, "status after reset");
      xfer(1'b0, 12'h020, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped error");
      run(`OPRP_CMD_RD_WORD, 18'h3, 16'h0, 1'b0, 32'h7, 32'h2);
      chk(rv, 32'hffff, "erased word");
      run(`OPRP_CMD_PROGRAM, 18'h3, 16'h12a5, 1'b0, 32'h1f07, 32'h0102);
      run(`OPRP_CMD_PROGRAM, 18'h3, 16'h00ff, 1'b0, 32'h1f07, 32'h1906);
      run(`OPRP_CMD_PROGRAM, 18'h5, 16'hbeef, 1'b0, 32'h1f07, 32'h0102);
      for (int i = 0; i < 2; i++) begin
         run(`OPRP_CMD_RD_WORD, adr[i], 16'h0, 1'b0, 32'h7, 32'h2);
         chk(rv, {16'h0, val[i]}, "re-verify word");
      end
      for (int h = 0; h < 2; h++) begin
         run(`OPRP_CMD_RD_BYTE, 18'h5, 16'h0, h[0], 32'h7, 32'h2);
         chk(rv, h ? 32'hbe : 32'hef, "byte read");
      end
      xfer(1'b0, `OPRP_REG_CTRL, 32'h0);
      chk(rv, 32'h102, "ctrl readback");
      run(`OPRP_CMD_VERIFY, 18'h5, 16'hbeef, 1'b0, 32'h7, 32'h2);
      run(`OPRP_CMD_VERIFY, 18'h5, 16'hbeee, 1'b0, 32'h7, 32'h6);
      for (int i = 0; i < 2; i++) begin
         run(`OPRP_CMD_RD_ID, 18'(i), 16'h0, 1'b0, 32'hf, 32'ha);
         chk(rv, i ? 32'h8003 : 32'h0034, "identify word");
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
